// file: pkg/egs_cfg.svh
`ifndef EGS_CFG_SVH
`define EGS_CFG_SVH
// Operation
// - Accelerator volts map linearly to target speed; 0.7 V low idle, 3.0 V high idle.
// - Both idle endpoint voltages are configurable, reversed slope allowed.
// - Accelerator below 0.2 V or above 4.6 V flags a sensor fault.
// - Measurement error plus hysteresis totals 0.125 V; sensor must keep margin.
// - Target speed comes from accelerator voltage or from a CAN speed value.
// - High-side input: NO closed reads high, NC actuated reads low.
// - Low-side input: NO closed reads low, NC actuated reads high.
// - Each contact input selects NO or NC; NO is default.
// - Output transistor on is logical one, off is logical zero.
// - High-side output terminal high when off; low-side terminal low when off.
// - Rack solenoid current is set by PWM on-time of a high-side transistor.
// - Valve stepper uses two-phase excitation with holding current always on.
// - Valve position tracked in steps, 0 closed to 54 open.
// - After key-off, power relay held until logs saved and valve closed.
// - Power self-hold can also be activated by a CAN command.
// - Rack self-test runs after power-on; starter disabled until it completes.
// - With preheat enabled, aid relay time from coolant; preheat lamp lit.
// - After preheat wait for start key; start key or 240 moves rack to start.
// - At 600 enter speed control, rack follows accelerator speed command; in RUN the rack duty is the fixed run_duty register, not target_rpm.
// - Engine stops when speed below 240 or key switched off.
// - Isochronous 0% or about 7% droop, flat until roughly 30% load.
// - Isochronous or droop selectable at runtime by switch or CAN, default set.
// - Speed from twelve cam pulses per revolution, rpm is ten times pulse Hz.
`define EGS_CLK_HZ 40000000
`define EGS_ADC_FS_MV 5000
`define EGS_ADC_MAX 1023
`define EGS_MV2CNT(mv) ((mv) * `EGS_ADC_MAX / `EGS_ADC_FS_MV)
`define EGS_ACC_LO_MV 700
`define EGS_ACC_HI_MV 3000
`define EGS_FLT_LO_MV 200
`define EGS_FLT_HI_MV 4600
`define EGS_HYST_MV 125
`define EGS_CRANK_RPM 240
`define EGS_RUN_RPM 600
`define EGS_CAM_PULSES 12
`define EGS_RPM_PER_HZ (2 * 60 / `EGS_CAM_PULSES)
`define EGS_GATE_MS 1000
`define EGS_TICK_MS 1
`define EGS_STEP_MS 4
`define EGS_VALVE_OPEN 54
`define EGS_DROOP_PCT 7
`define EGS_DROOP_KNEE_PCT 30
`define EGS_PCT_FULL 100
`define EGS_OFF_CTRL 8'h00
`define EGS_OFF_VLO 8'h04
`define EGS_OFF_VHI 8'h08
`define EGS_OFF_IDLE 8'h0c
`define EGS_OFF_CANRPM 8'h10
`define EGS_OFF_CCFG 8'h14
`define EGS_OFF_OUT 8'h18
`define EGS_OFF_RACK 8'h1c
`define EGS_OFF_VALVE 8'h20
`define EGS_OFF_PREHEAT 8'h24
`define EGS_OFF_STATUS 8'h28
`define EGS_OFF_SPEED 8'h2c
`define EGS_CTRL_RST 6'h02
`define EGS_LO_IDLE_RST 16'h0320
`define EGS_HI_IDLE_RST 16'h0a28
`define EGS_PREHEAT_RST 16'h0bb8
`define EGS_COLD_RST 10'h200
`endif

// file: pkg/egs_pkg.sv
package egs_pkg;
  typedef enum logic [2:0] {
    EGS_SELFTEST = 3'b000,
    EGS_PREHEAT = 3'b001,
    EGS_WAIT_START = 3'b010,
    EGS_CRANK = 3'b011,
    EGS_RUN = 3'b100,
    EGS_STOP = 3'b101
  } egs_state_e;
  typedef enum logic [3:0] {
    EGS_R_CTRL = 4'h0,
    EGS_R_VLO = 4'h1,
    EGS_R_VHI = 4'h2,
    EGS_R_IDLE = 4'h3,
    EGS_R_CANRPM = 4'h4,
    EGS_R_CCFG = 4'h5,
    EGS_R_OUT = 4'h6,
    EGS_R_RACK = 4'h7,
    EGS_R_VALVE = 4'h8,
    EGS_R_PREHEAT = 4'h9,
    EGS_R_STATUS = 4'ha,
    EGS_R_SPEED = 4'hb,
    EGS_R_NONE = 4'hf
  } egs_reg_e;
endpackage

// file: rtl/egs_pwm.sv
`timescale 1ns/1ps
module egs_pwm #(
  parameter int unsigned DW = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [DW-1:0] duty,
  output logic pwm_on
);
  typedef struct packed {
    logic [DW-1:0] cnt;
    logic on;
  } egs_pwm_s;
  egs_pwm_s q, d;
  always_comb begin
    d = q;
    d.cnt = q.cnt + 1'b1;
    d.on = (q.cnt < duty);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign pwm_on = q.on;
endmodule

// file: rtl/egs_io_sequencer.sv
`timescale 1ns/1ps
`include "egs_cfg.svh"
module egs_io_sequencer #(
  parameter int unsigned NIN = 4,
  parameter int unsigned NOUT = 4,
  parameter int unsigned GATE_CYC = `EGS_CLK_HZ / 1000 * `EGS_GATE_MS,
  parameter int unsigned MS_CYC = `EGS_CLK_HZ / 1000 * `EGS_TICK_MS,
  parameter int unsigned STEP_CYC = `EGS_CLK_HZ / 1000 * `EGS_STEP_MS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [9:0] accel_adc,
  input wire logic [9:0] coolant_adc,
  input wire logic [6:0] load_pct,
  input wire logic cam_pulse,
  input wire logic key_on,
  input wire logic key_start,
  input wire logic [NIN-1:0] contact_in,
  input wire logic rack_diag_done,
  input wire logic log_saved,
  output logic rack_pwm,
  output logic [3:0] valve_phase,
  output logic main_relay,
  output logic starter_relay,
  output logic aid_relay,
  output logic preheat_lamp,
  output logic [NOUT-1:0] out_on,
  output logic [NOUT-1:0] out_level,
  output logic [NIN-1:0] contact_active,
  output logic accel_fault,
  output logic droop_active,
  output logic [15:0] target_rpm,
  output logic [15:0] engine_rpm
);
  localparam logic [9:0] FLT_LO = 10'(`EGS_MV2CNT(`EGS_FLT_LO_MV));
  localparam logic [9:0] FLT_HI = 10'(`EGS_MV2CNT(`EGS_FLT_HI_MV));
  localparam logic [9:0] HYST = 10'(`EGS_MV2CNT(`EGS_HYST_MV));
  localparam logic [15:0] CRANK_RPM = 16'(`EGS_CRANK_RPM);
  localparam logic [15:0] RUN_RPM = 16'(`EGS_RUN_RPM);
  localparam logic [5:0] VOPEN = 6'(`EGS_VALVE_OPEN);
  typedef struct packed {
    egs_pkg::egs_state_e state;
    logic [5:0] ctrl;
    logic [9:0] vlo, vhi;
    logic [15:0] lo_idle, hi_idle, can_rpm;
    logic [NIN-1:0] nc_sel, lo_side;
    logic [NOUT-1:0] out_log, out_hs, out_lvl;
    logic [9:0] run_duty;
    logic [9:0] start_duty;
    logic [9:0] duty;
    logic [5:0] valve_tgt;
    logic [15:0] preheat_ms;
    logic [9:0] cold_thr;
    logic [31:0] prdata;
    logic pslverr;
    logic key_s1, key_s2, st_s1, st_s2, cam_s1, cam_s2, cam_s3;
    logic [NIN-1:0] ci_s1, ci_s2;
    logic [NIN-1:0] active;
    logic [31:0] gate_cnt;
    logic [15:0] pulse_cnt;
    logic [15:0] rpm;
    logic [31:0] ms_cnt;
    logic [15:0] ph_cnt;
    logic [31:0] step_cnt;
    logic [5:0] valve_pos;
    logic [1:0] phase;
    logic fault;
    logic droop;
    logic [15:0] target;
    logic relay;
  } egs_seq_s;
  egs_seq_s q, d;
  function automatic egs_pkg::egs_reg_e reg_of(input logic [7:0] a);
    if (a == `EGS_OFF_CTRL) reg_of = egs_pkg::EGS_R_CTRL;
    else if (a == `EGS_OFF_VLO) reg_of = egs_pkg::EGS_R_VLO;
    else if (a == `EGS_OFF_VHI) reg_of = egs_pkg::EGS_R_VHI;
    else if (a == `EGS_OFF_IDLE) reg_of = egs_pkg::EGS_R_IDLE;
    else if (a == `EGS_OFF_CANRPM) reg_of = egs_pkg::EGS_R_CANRPM;
    else if (a == `EGS_OFF_CCFG) reg_of = egs_pkg::EGS_R_CCFG;
    else if (a == `EGS_OFF_OUT) reg_of = egs_pkg::EGS_R_OUT;
    else if (a == `EGS_OFF_RACK) reg_of = egs_pkg::EGS_R_RACK;
    else if (a == `EGS_OFF_VALVE) reg_of = egs_pkg::EGS_R_VALVE;
    else if (a == `EGS_OFF_PREHEAT) reg_of = egs_pkg::EGS_R_PREHEAT;
    else if (a == `EGS_OFF_STATUS) reg_of = egs_pkg::EGS_R_STATUS;
    else if (a == `EGS_OFF_SPEED) reg_of = egs_pkg::EGS_R_SPEED;
    else reg_of = egs_pkg::EGS_R_NONE;
  endfunction
  function automatic logic [3:0] coils(input logic [1:0] p);
    case (p)
      2'h0: coils = 4'h3;
      2'h1: coils = 4'h6;
      2'h2: coils = 4'hc;
      default: coils = 4'h9;
    endcase
  endfunction
  always_comb begin
    logic signed [31:0] dv;
    logic signed [31:0] span;
    logic signed [31:0] lin;
    logic [31:0] drop;
    logic [5:0] vt;
    logic tick;
    egs_pkg::egs_reg_e ra;
    dv = '0;
    span = '0;
    lin = '0;
    drop = '0;
    vt = '0;
    tick = 1'b0;
    ra = reg_of(paddr);
    d = q;
    d.key_s1 = key_on;
    d.key_s2 = q.key_s1;
    d.st_s1 = key_start;
    d.st_s2 = q.st_s1;
    d.cam_s1 = cam_pulse;
    d.cam_s2 = q.cam_s1;
    d.cam_s3 = q.cam_s2;
    d.ci_s1 = contact_in;
    d.ci_s2 = q.ci_s1;
    d.active = q.ci_s2 ^ q.lo_side ^ q.nc_sel;
    d.out_lvl = q.out_log ^ q.out_hs;
    if (q.gate_cnt >= GATE_CYC - 1) begin
      d.gate_cnt = '0;
      d.pulse_cnt = '0;
      d.rpm = 16'(32'(q.pulse_cnt) * `EGS_RPM_PER_HZ * 1000 / `EGS_GATE_MS);
    end else begin
      d.gate_cnt = q.gate_cnt + 1;
      if (q.cam_s2 && !q.cam_s3) begin
        d.pulse_cnt = q.pulse_cnt + 16'h0001;
      end
    end
    if (q.ms_cnt >= MS_CYC - 1) begin
      d.ms_cnt = '0;
      tick = 1'b1;
    end else begin
      d.ms_cnt = q.ms_cnt + 1;
    end
    if (accel_adc < FLT_LO || accel_adc > FLT_HI) begin
      d.fault = 1'b1;
    end else if (accel_adc >= FLT_LO + HYST && accel_adc <= FLT_HI - HYST) begin
      d.fault = 1'b0;
    end
    dv = 32'(signed'({1'b0, accel_adc})) - 32'(signed'({1'b0, q.vlo}));
    span = 32'(signed'({1'b0, q.vhi})) - 32'(signed'({1'b0, q.vlo}));
    if (span != 0) begin
      lin = 32'(signed'({1'b0, q.lo_idle})) + dv * (32'(signed'({1'b0, q.hi_idle}))
            - 32'(signed'({1'b0, q.lo_idle}))) / span;
    end else begin
      lin = 32'(signed'({1'b0, q.lo_idle}));
    end
    if (q.ctrl[0]) begin
      lin = 32'(signed'({1'b0, q.can_rpm}));
    end
    d.droop = q.ctrl[3] ? q.ctrl[4] : (q.ctrl[2] ^ q.active[0]);
    if (q.droop && load_pct > 7'(`EGS_DROOP_KNEE_PCT)) begin
      drop = 32'(lin) * `EGS_DROOP_PCT * 32'(load_pct - 7'(`EGS_DROOP_KNEE_PCT))
             / (`EGS_PCT_FULL * (`EGS_PCT_FULL - `EGS_DROOP_KNEE_PCT));
      lin = lin - signed'(drop);
    end
    if (lin < 32'(signed'({1'b0, q.lo_idle}))) begin
      lin = 32'(signed'({1'b0, q.lo_idle}));
    end else if (lin > 32'(signed'({1'b0, q.hi_idle}))) begin
      lin = 32'(signed'({1'b0, q.hi_idle}));
    end
    if (q.ctrl[0] || !q.fault) begin
      d.target = lin[15:0];
    end
    case (q.state)
      egs_pkg::EGS_SELFTEST: begin
        if (rack_diag_done) begin
          d.state = egs_pkg::EGS_PREHEAT;
          d.ph_cnt = (coolant_adc > q.cold_thr) ? q.preheat_ms : 16'h0000;
        end
      end
      egs_pkg::EGS_PREHEAT: begin
        if (!q.ctrl[1] || q.ph_cnt == 16'h0000) begin
          d.state = egs_pkg::EGS_WAIT_START;
        end else if (tick) begin
          d.ph_cnt = q.ph_cnt - 16'h0001;
        end
      end
      egs_pkg::EGS_WAIT_START: begin
        if (!q.key_s2) begin
          d.state = egs_pkg::EGS_STOP;
        end else if (q.st_s2 || q.rpm >= CRANK_RPM) begin
          d.state = egs_pkg::EGS_CRANK;
        end
      end
      egs_pkg::EGS_CRANK: begin
        if (!q.key_s2) begin
          d.state = egs_pkg::EGS_STOP;
        end else if (q.rpm >= RUN_RPM) begin
          d.state = egs_pkg::EGS_RUN;
        end
      end
      egs_pkg::EGS_RUN: begin
        if (!q.key_s2 || q.rpm < CRANK_RPM) begin
          d.state = egs_pkg::EGS_STOP;
        end
      end
      default: begin
        if (q.key_s2) begin
          d.state = egs_pkg::EGS_WAIT_START;
        end
      end
    endcase
    case (d.state)
      egs_pkg::EGS_CRANK: d.duty = q.start_duty;
      egs_pkg::EGS_RUN: d.duty = q.run_duty;
      default: d.duty = '0;
    endcase
    vt = (q.valve_tgt > VOPEN) ? VOPEN : q.valve_tgt;
    if (q.state == egs_pkg::EGS_STOP || !q.key_s2) begin
      vt = '0;
    end
    if (q.valve_pos == vt) begin
      d.step_cnt = '0;
    end else if (q.step_cnt >= STEP_CYC - 1) begin
      d.step_cnt = '0;
      if (q.valve_pos < vt) begin
        d.valve_pos = q.valve_pos + 6'h01;
        d.phase = q.phase + 2'h1;
      end else begin
        d.valve_pos = q.valve_pos - 6'h01;
        d.phase = q.phase - 2'h1;
      end
    end else begin
      d.step_cnt = q.step_cnt + 1;
    end
    d.relay = q.key_s2 || q.ctrl[5] || !log_saved || q.valve_pos != 6'h00;
    d.pslverr = 1'b0;
    if (psel && !penable) begin
      d.prdata = '0;
      d.pslverr = (ra == egs_pkg::EGS_R_NONE);
      if (ra == egs_pkg::EGS_R_CTRL) d.prdata = 32'(q.ctrl);
      else if (ra == egs_pkg::EGS_R_VLO) d.prdata = 32'(q.vlo);
      else if (ra == egs_pkg::EGS_R_VHI) d.prdata = 32'(q.vhi);
      else if (ra == egs_pkg::EGS_R_IDLE) d.prdata = {q.hi_idle, q.lo_idle};
      else if (ra == egs_pkg::EGS_R_CANRPM) d.prdata = 32'(q.can_rpm);
      else if (ra == egs_pkg::EGS_R_CCFG) d.prdata = {8'h00, 8'(q.active), 8'(q.lo_side), 8'(q.nc_sel)};
      else if (ra == egs_pkg::EGS_R_OUT) d.prdata = {16'h0000, 8'(q.out_hs), 8'(q.out_log)};
      else if (ra == egs_pkg::EGS_R_RACK) d.prdata = {6'h00, q.start_duty, 6'h00, q.run_duty};
      else if (ra == egs_pkg::EGS_R_VALVE) d.prdata = {10'h000, q.valve_pos, 10'h000, q.valve_tgt};
      else if (ra == egs_pkg::EGS_R_PREHEAT) d.prdata = {6'h00, q.cold_thr, q.preheat_ms};
      else if (ra == egs_pkg::EGS_R_STATUS) d.prdata = {24'h000000, q.relay, q.droop, q.fault, 2'h0, q.state};
      else if (ra == egs_pkg::EGS_R_SPEED) d.prdata = {q.target, q.rpm};
    end
    if (psel && penable && pwrite) begin
      if (ra == egs_pkg::EGS_R_CTRL) d.ctrl = pwdata[5:0];
      else if (ra == egs_pkg::EGS_R_VLO) d.vlo = pwdata[9:0];
      else if (ra == egs_pkg::EGS_R_VHI) d.vhi = pwdata[9:0];
      else if (ra == egs_pkg::EGS_R_IDLE) {d.hi_idle, d.lo_idle} = pwdata;
      else if (ra == egs_pkg::EGS_R_CANRPM) d.can_rpm = pwdata[15:0];
      else if (ra == egs_pkg::EGS_R_CCFG) begin
        d.nc_sel = pwdata[NIN-1:0];
        d.lo_side = pwdata[8 +: NIN];
      end else if (ra == egs_pkg::EGS_R_OUT) begin
        d.out_log = pwdata[NOUT-1:0];
        d.out_hs = pwdata[8 +: NOUT];
      end else if (ra == egs_pkg::EGS_R_RACK) begin
        d.run_duty = pwdata[9:0];
        d.start_duty = pwdata[25:16];
      end else if (ra == egs_pkg::EGS_R_VALVE) d.valve_tgt = pwdata[5:0];
      else if (ra == egs_pkg::EGS_R_PREHEAT) begin
        d.preheat_ms = pwdata[15:0];
        d.cold_thr = pwdata[25:16];
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.state <= egs_pkg::EGS_SELFTEST;
      q.ctrl <= `EGS_CTRL_RST;
      q.vlo <= 10'(`EGS_MV2CNT(`EGS_ACC_LO_MV));
      q.vhi <= 10'(`EGS_MV2CNT(`EGS_ACC_HI_MV));
      q.lo_idle <= `EGS_LO_IDLE_RST;
      q.hi_idle <= `EGS_HI_IDLE_RST;
      q.preheat_ms <= `EGS_PREHEAT_RST;
      q.cold_thr <= `EGS_COLD_RST;
      q.relay <= 1'b1;
    end else begin
      q <= d;
    end
  end
  egs_pwm #(.DW(10)) egs_pwm_i (
    .pclk(pclk),
    .presetn(presetn),
    .duty(q.duty),
    .pwm_on(rack_pwm)
  );
  assign prdata = q.prdata;
  assign pready = 1'b1;
  assign pslverr = q.pslverr;
  assign valve_phase = coils(q.phase);
  assign main_relay = q.relay;
  assign starter_relay = q.st_s2 && q.state inside {egs_pkg::EGS_WAIT_START, egs_pkg::EGS_CRANK};
  assign aid_relay = (q.state == egs_pkg::EGS_PREHEAT);
  assign preheat_lamp = (q.state == egs_pkg::EGS_PREHEAT);
  assign out_on = q.out_log;
  assign out_level = q.out_lvl;
  assign contact_active = q.active;
  assign accel_fault = q.fault;
  assign droop_active = q.droop;
  assign target_rpm = q.target;
  assign engine_rpm = q.rpm;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_fault_set;
    (accel_adc < FLT_LO || accel_adc > FLT_HI) |=> accel_fault;
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault not flagged");
  property p_fault_hold;
    accel_fault && accel_adc < FLT_LO + HYST |=> accel_fault;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault hysteresis lost");
  property p_no_starter;
    q.state == egs_pkg::EGS_SELFTEST |-> !starter_relay;
  endproperty
  a_no_starter: assert property (p_no_starter) else $error("starter before self-test");
  property p_preheat;
    $rose(q.state == egs_pkg::EGS_PREHEAT) |-> preheat_lamp && aid_relay;
  endproperty
  a_preheat: assert property (p_preheat) else $error("preheat outputs off");
  property p_crank;
    q.state == egs_pkg::EGS_WAIT_START && q.key_s2 && q.st_s2
      |=> q.state == egs_pkg::EGS_CRANK ##1 q.duty == q.start_duty;
  endproperty
  a_crank: assert property (p_crank) else $error("no crank on start key");
  property p_run;
    q.state == egs_pkg::EGS_CRANK && q.key_s2 && engine_rpm >= RUN_RPM
      |=> q.state == egs_pkg::EGS_RUN;
  endproperty
  a_run: assert property (p_run) else $error("speed control not entered");
  property p_stop;
    q.state == egs_pkg::EGS_RUN && engine_rpm < CRANK_RPM |=> q.state == egs_pkg::EGS_STOP;
  endproperty
  a_stop: assert property (p_stop) else $error("engine not stopped");
  property p_hold;
    q.valve_pos != 6'h00 ##1 1'b1 |-> main_relay;
  endproperty
  a_hold: assert property (p_hold) else $error("relay dropped with valve open");
  property p_valve;
    q.valve_pos <= VOPEN && $countones(valve_phase) == 2;
  endproperty
  a_valve: assert property (p_valve) else $error("valve range or coils wrong");
  property p_outlvl;
    out_on == $past(q.out_log) |-> out_level == (out_on ^ $past(q.out_hs));
  endproperty
  a_outlvl: assert property (p_outlvl) else $error("output level wrong");
  c_run: cover property (q.state == egs_pkg::EGS_CRANK ##1 q.state == egs_pkg::EGS_RUN);
  c_fault: cover property ($rose(accel_fault));
  c_close: cover property (!q.key_s2 && q.valve_pos == 6'h01 ##[1:1000] !main_relay);
endmodule

// file: sim/egs_engine_model.sv
`timescale 1ns/1ps
module egs_engine_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic key_on,
  input wire logic [7:0] period,
  output logic cam_pulse,
  output logic rack_diag_done,
  output logic log_saved
);
  typedef struct packed {
    logic [7:0] ph;
    logic [7:0] diag;
    logic [5:0] save;
  } egs_model_s;
  egs_model_s st_q;
  egs_model_s st_d;
  // Cam pulser, half period high, silent when period is zero
  assign cam_pulse = (period != 8'h00) && (st_q.ph < (period >> 1));
  // Self-test finishes some time after power-on
  assign rack_diag_done = (st_q.diag == 8'h64);
  // Log store starts at key-off and takes a while
  assign log_saved = (st_q.save == 6'h28);
  always_comb begin
    st_d = st_q;
    st_d.ph = (st_q.ph + 8'h01 >= period) ? 8'h00 : st_q.ph + 8'h01;
    if (!rack_diag_done) begin
      st_d.diag = st_q.diag + 8'h01;
    end
    if (key_on) begin
      st_d.save = 6'h00;
    end else if (!log_saved) begin
      st_d.save = st_q.save + 6'h01;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule

// file: sim/test_egs_io_sequencer.sv
`timescale 1ns/1ps
module test_egs_io_sequencer;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [9:0] accel_adc = 10'h12c;
  logic [9:0] coolant_adc = 10'h258;
  logic [6:0] load_pct = 7'h14;
  logic key_on = 1'b1;
  logic key_start = 1'b1;
  logic [3:0] contact_in = 4'h0;
  logic [7:0] period = 8'h00;
  logic [31:0] prdata;
  logic pready, pslverr, cam_pulse, rack_diag_done, log_saved, rack_pwm, main_relay;
  logic starter_relay, aid_relay, preheat_lamp, accel_fault, droop_active;
  logic [3:0] valve_phase, out_on, out_level, contact_active;
  logic [15:0] target_rpm, engine_rpm;
  logic [65:0] rq[$];
  logic [65:0] e;
  integer error_cnt = 0;
  integer checked = 0;
  integer seed = 32'h1853;
  egs_io_sequencer #(.GATE_CYC(1000), .MS_CYC(10), .STEP_CYC(4)) egs_io_sequencer_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .accel_adc, .coolant_adc, .load_pct, .cam_pulse, .key_on, .key_start, .contact_in,
    .rack_diag_done, .log_saved, .rack_pwm, .valve_phase, .main_relay, .starter_relay,
    .aid_relay, .preheat_lamp, .out_on, .out_level, .contact_active, .accel_fault,
    .droop_active, .target_rpm, .engine_rpm
  );
  egs_engine_model egs_engine_model_i (
    .pclk, .presetn, .key_on, .period, .cam_pulse, .rack_diag_done, .log_saved
  );
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // APB master; a read leaves its expected value and mask in the queue
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] ex = '0, input logic [32:0] m = '0);
    int n;
    @(posedge pclk);
    if (!w) begin
      rq.push_back({ex, m});
    end
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      error_cnt++;
      stop_test();
    end
  endtask
  function automatic logic [32:0] obs(input int k);
    case (k)
      0: obs = 33'(target_rpm);
      1: obs = 33'(contact_active);
      2: obs = 33'(out_on);
      3: obs = 33'(out_level);
      4: obs = 33'(accel_fault);
      5: obs = 33'(droop_active);
      6: obs = 33'(starter_relay);
      7: obs = 33'({aid_relay, preheat_lamp});
      default: obs = 33'(main_relay);
    endcase
  endfunction
  task automatic wait_obs(input int k, input logic [32:0] ex, input int lim);
    int n;
    n = 0;
    while (obs(k) !== ex && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk(obs(k), ex);
    if (obs(k) !== ex) begin
      stop_test();
    end
  endtask
  always @(posedge pclk) begin
    if (presetn) begin
      chk(33'($countones(valve_phase) == 2), 33'h1);
      if (psel && penable && pready && !pwrite) begin
        e = rq.pop_front();
        chk({pslverr, prdata} & e[32:0], e[65:33]);
      end
    end
  end
  initial begin
    logic [31:0] v;
    logic [10:0] pc;
    logic [10:0] ft[8] = '{11'h028, 11'h427, 11'h440, 11'h041, 11'h3ad, 11'h7ae, 11'h795,
                           11'h394};
    logic [9:0] ta[3] = '{10'h08f, 10'h17a, 10'h265};
    logic [15:0] tr[3] = '{16'h0320, 16'h06a4, 16'h0a28};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, 8'h24, 32'h0200_0014);
    apb(1'b0, 8'h24, 32'h0, 33'h0_0200_0014, 33'h1_03ff_ffff);
    apb(1'b0, 8'h00, 32'h0, 33'h0_0000_0002, 33'h1_0000_003f);
    apb(1'b0, 8'h04, 32'h0, 33'h0_0000_008f, 33'h1_0000_03ff);
    apb(1'b0, 8'h08, 32'h0, 33'h0_0000_0265, 33'h1_0000_03ff);
    apb(1'b0, 8'h0c, 32'h0, 33'h0_0a28_0320, 33'h1_ffff_ffff);
    apb(1'b0, 8'h30, 32'h0, 33'h1_0000_0000, 33'h1_ffff_ffff);
    repeat (40) begin
      @(posedge pclk);
      if (rack_diag_done !== 1'b1) chk(33'(starter_relay), 33'h0);
    end
    wait_obs(7, 33'h3, 200);
    wait_obs(7, 33'h0, 400);
    wait_obs(6, 33'h1, 10);
    key_start <= 1'b0;
    $display("start sequence done");
    for (int c = 0; c < 4; c++) begin
      v = $random(seed);
      apb(1'b1, 8'h14, {16'h0, {8{c[0]}}, {8{c[1]}}});
      contact_in <= v[3:0];
      wait_obs(1, 33'(v[3:0] ^ {4{c[0]}} ^ {4{c[1]}}), 8);
    end
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      apb(1'b1, 8'h18, v);
      wait_obs(2, 33'(v[3:0]), 4);
      wait_obs(3, 33'(v[3:0] ^ v[11:8]), 4);
    end
    foreach (ft[i]) begin
      accel_adc <= ft[i][9:0];
      repeat (4) @(posedge pclk);
      wait_obs(4, 33'(ft[i][10]), 4);
    end
    $display("contact and fault tests done");
    for (int r = 0; r < 2; r++) begin
      apb(1'b1, 8'h04, r ? 32'h265 : 32'h08f);
      apb(1'b1, 8'h08, r ? 32'h08f : 32'h265);
      foreach (ta[i]) begin
        accel_adc <= ta[i];
        wait_obs(0, 33'(r ? 16'h0d48 - tr[i] : tr[i]), 10);
      end
    end
    apb(1'b1, 8'h04, 32'h08f);
    apb(1'b1, 8'h08, 32'h265);
    apb(1'b1, 8'h00, 32'h3);
    apb(1'b1, 8'h10, 32'h4d2);
    wait_obs(0, 33'h4d2, 10);
    load_pct <= 7'h50;
    apb(1'b1, 8'h00, 32'h1a);
    wait_obs(5, 33'h1, 6);
    wait_obs(0, 33'h9a6, 10);
    load_pct <= 7'h1e;
    wait_obs(0, 33'ha28, 10);
    apb(1'b1, 8'h14, 32'h0);
    apb(1'b1, 8'h00, 32'h2);
    contact_in <= 4'h1;
    wait_obs(5, 33'h1, 8);
    apb(1'b1, 8'h00, 32'h6);
    wait_obs(5, 33'h0, 6);
    apb(1'b1, 8'h00, 32'h2);
    $display("target speed tests done");
    apb(1'b1, 8'h1c, 32'h03ff_0100);
    period <= 8'h0a;
    repeat (2500) @(posedge pclk);
    chk(33'(engine_rpm >= 16'd990 && engine_rpm <= 16'd1010), 33'h1);
    apb(1'b0, 8'h28, 32'h0, 33'h0_0000_0004, 33'h0_0000_0007);
    pc = '0;
    repeat (1024) begin
      @(posedge pclk);
      pc = pc + 11'(rack_pwm);
    end
    chk(33'(pc), 33'h100);
    apb(1'b1, 8'h20, 32'h3c);
    repeat (300) @(posedge pclk);
    apb(1'b0, 8'h20, 32'h0, 33'h0_0036_0000, 33'h1_003f_0000);
    period <= 8'h00;
    repeat (2500) @(posedge pclk);
    // Key still on, so the stopped sequencer re-arms to wait for start
    apb(1'b0, 8'h28, 32'h0, 33'h0_0000_0082, 33'h0_0000_0087);
    key_on <= 1'b0;
    repeat (20) @(posedge pclk);
    chk(33'(main_relay), 33'h1);
    wait_obs(8, 33'h0, 600);
    apb(1'b0, 8'h20, 32'h0, 33'h0_0000_0000, 33'h1_003f_0000);
    apb(1'b1, 8'h00, 32'h22);
    wait_obs(8, 33'h1, 6);
    apb(1'b1, 8'h00, 32'h2);
    key_on <= 1'b1;
    $display("stop and self-hold tests done");
    stop_test();
  end
endmodule
